// [rtl/mcu_watchdog.sv]
// How it works
// - Drive-enable output is forced low whenever the watchdog judges the MCU faulty.
// - Each entry from reset into diagnostic state starts in pulse-trigger mode.
// - In question-answer mode answers arrive as bus writes and are evaluated.
// - In question-answer mode the error monitor on the pin is allowed.
// - Fail count five or more: out of range, drive-enable held low.
// - Fail count four or less: in range; drive follows request and errors.
// - Fail counting is the same whether reset-enable is set or not.
// - Good event decrements fail count, stopping at zero.
// - Bad event increments fail count, stopping at seven.
// - Time-out increments fail count and sets status time-out flag, bit 1.
// - Fail count loads five on entering diagnostic and on going active.
// - Reset-enable and count seven: next bad or time-out resets the MCU.
// - Entering reset through the watchdog reloads the fail count to five.
// - Reset-enable set while count is seven enters reset at once.
// - Trigger is a rise then a fall more than 32 us later.
// - Response in closed window is bad, restarts sequence, sets early flag.
// - Response in open window is good, or bad for a wrong Q&A answer; either restarts the sequence.
// - No response by sequence end is a time-out; steps are 0.55 ms.
`include "watchdog_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mcu_watchdog #(
    parameter int unsigned STEP_CYC = `WD_STEP_CYC,
    parameter int unsigned PULSE_CYC = `TRIG_PULSE_CYC,
    parameter int unsigned RESET_HOLD = `RESET_HOLD_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // MCU side pins
    input wire logic i_mcu_error_trigger_in,
    input wire logic i_other_error,
    output logic o_drive_enable_out,
    output logic o_mcu_reset_out_n,
    output logic o_error_signal_monitor_en
);
    logic rst_meta_q;
    logic rst_n;
    logic trig_meta_q;
    logic trig_sync_q;
    logic restart;

    timing_if tif ();

    // Reset release
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Pin synchroniser
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta_q <= 1'b0;
            trig_sync_q <= 1'b0;
        end else begin
            trig_meta_q <= i_mcu_error_trigger_in;
            trig_sync_q <= trig_meta_q;
        end
    end

    step_timer #(.STEP_CYC(STEP_CYC)) u_step (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_restart(restart),
        .tif(tif.timer)
    );

    trigger_detect #(.PULSE_CYC(PULSE_CYC)) u_trig (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_level(trig_sync_q),
        .tif(tif.detect)
    );

    // Register state
    watchdog_pkg::dev_state_t state_q, state_d;
    watchdog_pkg::win_phase_t phase_q, phase_d;
    logic [7:0] hold_q, hold_d;
    logic rst_en_q, rst_en_d;
    logic qa_mode_q, qa_mode_d;
    logic drv_req_q, drv_req_d;
    logic [6:0] win1_q, win1_d;
    logic [4:0] win2_q, win2_d;
    logic [6:0] step_q, step_d;
    logic [2:0] fail_q, fail_d;
    logic pend_good_q, pend_good_d;
    logic pend_bad_q, pend_bad_d;
    logic pend_to_q, pend_to_d;
    logic early_q, early_d;
    logic timeout_q, timeout_d;
    logic [3:0] question_q, question_d;
    logic drive_q, drive_d;
    logic mres_q, mres_d;
    logic [31:0] rdata_q, rdata_d;
    logic slverr_q, slverr_d;

    // Bus decode
    logic setup;
    logic access;
    logic wr;
    logic addr_ok;
    logic wr_cfg, wr_ctrl, wr_win1, wr_win2, wr_stat, wr_ans;
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite;
    assign addr_ok = (i_paddr == `ADDR_SAFETY_CFG) || (i_paddr == `ADDR_CTRL)
        || (i_paddr == `ADDR_WIN1) || (i_paddr == `ADDR_WIN2)
        || (i_paddr == `ADDR_STATUS) || (i_paddr == `ADDR_QA);
    assign wr_cfg = wr && (i_paddr == `ADDR_SAFETY_CFG);
    assign wr_ctrl = wr && (i_paddr == `ADDR_CTRL);
    assign wr_win1 = wr && (i_paddr == `ADDR_WIN1);
    assign wr_win2 = wr && (i_paddr == `ADDR_WIN2);
    assign wr_stat = wr && (i_paddr == `ADDR_STATUS);
    assign wr_ans = wr && (i_paddr == `ADDR_QA);
    assign o_pready = access;
    assign o_pslverr = access && slverr_q;
    assign o_prdata = rdata_q;

    // Event and update terms
    logic run, in_diag;
    logic resp, resp_ok, ans_ok;
    logic ev_good, ev_bad, ev_to;
    logic apply_good, apply_inc, apply_to;
    logic rst_en_rise, wd_reset;

    assign run = (state_q != watchdog_pkg::st_reset);
    assign in_diag = (state_q == watchdog_pkg::st_diag);
    assign ans_ok = (i_pwdata[7:0] == {~question_q, question_q});
    // Trigger pin counts only in trigger mode, bus answers only in Q&A mode
    assign resp = qa_mode_q ? wr_ans : tif.trigger;
    assign resp_ok = qa_mode_q ? ans_ok : 1'b1;
    assign rst_en_rise = wr_cfg && in_diag && i_pwdata[`CFG_RST_EN_BIT] && !rst_en_q;

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        hold_d = hold_q;
        rst_en_d = rst_en_q;
        qa_mode_d = qa_mode_q;
        drv_req_d = drv_req_q;
        win1_d = win1_q;
        win2_d = win2_q;
        step_d = step_q;
        fail_d = fail_q;
        question_d = question_q;
        restart = 1'b0;
        ev_good = 1'b0;
        ev_bad = 1'b0;
        ev_to = 1'b0;
        early_d = early_q && !(wr_stat && i_pwdata[`STAT_EARLY_BIT]);
        timeout_d = timeout_q && !(wr_stat && i_pwdata[`STAT_TIMEOUT_BIT]);

        // Configuration writes
        if (wr_cfg && in_diag) begin
            rst_en_d = i_pwdata[`CFG_RST_EN_BIT];
            qa_mode_d = i_pwdata[`CFG_QA_MODE_BIT];
        end
        if (wr_ctrl) begin
            drv_req_d = i_pwdata[`CTRL_DRV_REQ_BIT];
        end
        if (wr_win1 && in_diag) begin
            win1_d = i_pwdata[6:0];
        end
        if (wr_win2 && in_diag) begin
            win2_d = i_pwdata[4:0];
        end

        // Window sequence
        if (run) begin
            if (wr_win1 || wr_win2) begin
                ev_bad = 1'b1;
                restart = 1'b1;
            end else if (resp) begin
                restart = 1'b1;
                if (phase_q == watchdog_pkg::ph_closed) begin
                    ev_bad = 1'b1;
                    early_d = 1'b1;
                end else if (resp_ok) begin
                    ev_good = 1'b1;
                    question_d = question_q + 4'h1;
                end else begin
                    ev_bad = 1'b1;
                end
            end else if (tif.step_tick) begin
                if (phase_q == watchdog_pkg::ph_closed) begin
                    if ({1'b0, step_q} + 8'h01 >= {1'b0, win1_q}) begin
                        phase_d = watchdog_pkg::ph_open;
                        step_d = 7'h00;
                    end else begin
                        step_d = step_q + 7'h01;
                    end
                end else if (step_q >= {2'b00, win2_q}) begin
                    ev_to = 1'b1;
                    timeout_d = 1'b1;
                    restart = 1'b1;
                end else begin
                    step_d = step_q + 7'h01;
                end
            end
        end
        if (restart) begin
            phase_d = watchdog_pkg::ph_closed;
            step_d = 7'h00;
        end

        // Queue events, apply one per cycle: time-out, bad, then good
        pend_to_d = pend_to_q || ev_to;
        pend_bad_d = pend_bad_q || ev_bad;
        pend_good_d = pend_good_q || ev_good;
        apply_to = pend_to_d;
        apply_inc = pend_to_d || pend_bad_d;
        apply_good = !apply_inc && pend_good_d;
        if (apply_to) begin
            pend_to_d = 1'b0;
        end else if (pend_bad_d) begin
            pend_bad_d = 1'b0;
        end else begin
            pend_good_d = 1'b0;
        end

        // Counting ignores the reset-enable bit
        if (apply_inc && fail_q != `FAIL_MAX) begin
            fail_d = fail_q + 3'h1;
        end else if (apply_good && fail_q != `FAIL_MIN) begin
            fail_d = fail_q - 3'h1;
        end

        wd_reset = run && (fail_q == `FAIL_MAX)
            && ((rst_en_q && apply_inc) || rst_en_rise);

        // Device state
        case (state_q)
            watchdog_pkg::st_reset: begin
                fail_d = `FAIL_INIT;
                pend_to_d = 1'b0;
                pend_bad_d = 1'b0;
                pend_good_d = 1'b0;
                hold_d = hold_q + 8'h01;
                if (hold_q == 8'(RESET_HOLD - 1)) begin
                    state_d = watchdog_pkg::st_diag;
                    fail_d = `FAIL_INIT;
                    qa_mode_d = 1'b0;
                    win1_d = `WIN1_DEFAULT;
                    win2_d = `WIN2_DEFAULT;
                    restart = 1'b1;
                    phase_d = watchdog_pkg::ph_closed;
                    step_d = 7'h00;
                end
            end
            watchdog_pkg::st_diag: begin
                if (wd_reset) begin
                    state_d = watchdog_pkg::st_reset;
                    hold_d = 8'h00;
                    fail_d = `FAIL_INIT;
                end else if (wr_ctrl && i_pwdata[`CTRL_GO_ACTIVE_BIT]) begin
                    state_d = watchdog_pkg::st_active;
                    fail_d = `FAIL_INIT;
                end
            end
            watchdog_pkg::st_active: begin
                if (wd_reset) begin
                    state_d = watchdog_pkg::st_reset;
                    hold_d = 8'h00;
                    fail_d = `FAIL_INIT;
                end
            end
            default: begin
                state_d = watchdog_pkg::st_reset;
                hold_d = 8'h00;
            end
        endcase

        // Outputs
        drive_d = run && (fail_q <= `FAIL_IN_RANGE_MAX) && drv_req_q
            && !i_other_error;
        mres_d = (state_d != watchdog_pkg::st_reset);

        // Read data captured in the setup phase
        rdata_d = rdata_q;
        slverr_d = slverr_q;
        if (setup) begin
            slverr_d = !addr_ok;
            rdata_d = 32'h0000_0000;
            case (i_paddr)
                `ADDR_SAFETY_CFG: begin
                    rdata_d[`CFG_RST_EN_BIT] = rst_en_q;
                    rdata_d[`CFG_QA_MODE_BIT] = qa_mode_q;
                end
                `ADDR_CTRL: rdata_d[`CTRL_DRV_REQ_BIT] = drv_req_q;
                `ADDR_WIN1: rdata_d[6:0] = win1_q;
                `ADDR_WIN2: rdata_d[4:0] = win2_q;
                `ADDR_STATUS: begin
                    rdata_d[`STAT_EARLY_BIT] = early_q;
                    rdata_d[`STAT_TIMEOUT_BIT] = timeout_q;
                    rdata_d[`STAT_FAIL_LSB +: 3] = fail_q;
                    rdata_d[`STAT_STATE_LSB +: 2] = state_q;
                end
                `ADDR_QA: rdata_d[3:0] = question_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= watchdog_pkg::st_reset;
            phase_q <= watchdog_pkg::ph_closed;
            hold_q <= 8'h00;
            rst_en_q <= 1'b0;
            qa_mode_q <= 1'b0;
            drv_req_q <= 1'b0;
            win1_q <= `WIN1_DEFAULT;
            win2_q <= `WIN2_DEFAULT;
            step_q <= 7'h00;
            fail_q <= `FAIL_INIT;
            pend_good_q <= 1'b0;
            pend_bad_q <= 1'b0;
            pend_to_q <= 1'b0;
            early_q <= 1'b0;
            timeout_q <= 1'b0;
            question_q <= 4'h0;
            drive_q <= 1'b0;
            mres_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            hold_q <= hold_d;
            rst_en_q <= rst_en_d;
            qa_mode_q <= qa_mode_d;
            drv_req_q <= drv_req_d;
            win1_q <= win1_d;
            win2_q <= win2_d;
            step_q <= step_d;
            fail_q <= fail_d;
            pend_good_q <= pend_good_d;
            pend_bad_q <= pend_bad_d;
            pend_to_q <= pend_to_d;
            early_q <= early_d;
            timeout_q <= timeout_d;
            question_q <= question_d;
            drive_q <= drive_d;
            mres_q <= mres_d;
            rdata_q <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    assign o_drive_enable_out = drive_q;
    assign o_mcu_reset_out_n = mres_q;
    assign o_error_signal_monitor_en = qa_mode_q;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    a_out_range_drive: assert property (fail_q >= `FAIL_INIT |=> !o_drive_enable_out)
        else $error("Drive enable high while fail count out of range");
    a_in_range_drive: assert property (run && fail_q <= `FAIL_IN_RANGE_MAX && drv_req_q
        && !i_other_error |=> o_drive_enable_out)
        else $error("Drive enable low while in range and requested");
    a_error_forces_low: assert property (i_other_error |=> !o_drive_enable_out)
        else $error("Drive enable high during external error");
    a_good_decrement: assert property (run && apply_good && fail_q != `FAIL_MIN
        && state_d == state_q |=> fail_q == $past(fail_q) - 3'h1)
        else $error("Good event did not decrement fail count");
    a_bad_saturate: assert property (run && apply_inc && fail_q == `FAIL_MAX && !rst_en_q
        && state_d == state_q |=> fail_q == `FAIL_MAX)
        else $error("Fail count left seven on bad event");
    a_timeout_flag: assert property (ev_to ##1 !wr_stat |-> timeout_q [*2])
        else $error("Time-out flag not held after time-out");
    a_early_flag: assert property (run && resp && phase_q == watchdog_pkg::ph_closed
        |=> early_q && phase_q == watchdog_pkg::ph_closed && step_q == 7'h00)
        else $error("Closed-window response not flagged early");
    a_diag_entry: assert property (state_q == watchdog_pkg::st_reset
        && state_d == watchdog_pkg::st_diag |=> fail_q == `FAIL_INIT && !qa_mode_q)
        else $error("Diagnostic entry did not load five in trigger mode");
    a_wd_reset: assert property (run && rst_en_q && fail_q == `FAIL_MAX && apply_inc
        |=> state_q == watchdog_pkg::st_reset && !o_mcu_reset_out_n && fail_q == `FAIL_INIT)
        else $error("Saturated fail count did not reset the MCU");
    a_rst_en_now: assert property (rst_en_rise && fail_q == `FAIL_MAX
        |=> state_q == watchdog_pkg::st_reset)
        else $error("Reset enable at seven did not reset at once");
    a_one_update: assert property (state_d == state_q |=> fail_q == $past(fail_q)
        || fail_q == $past(fail_q) + 3'h1 || fail_q == $past(fail_q) - 3'h1)
        else $error("Fail count moved by more than one in a cycle");

    c_good_event: cover property (run && apply_good);
    c_timeout: cover property (ev_to);
    c_wd_reset: cover property (run && wd_reset);
    c_go_active: cover property (state_q == watchdog_pkg::st_active);
endmodule

`default_nettype wire

// [rtl/watchdog_consts.svh]
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

// Timing
`define CLK_PERIOD_NS 4
`define WD_STEP_NS 550000
`define TRIG_PULSE_NS 32000
`define WD_STEP_CYC (`WD_STEP_NS / `CLK_PERIOD_NS)
`define TRIG_PULSE_CYC ((`TRIG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_HOLD_CYC 16

// Register byte addresses
`define ADDR_SAFETY_CFG 8'h00
`define ADDR_CTRL 8'h04
`define ADDR_WIN1 8'h08
`define ADDR_WIN2 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_QA 8'h14

// Field positions
`define CFG_RST_EN_BIT 3
`define CFG_QA_MODE_BIT 5
`define CTRL_DRV_REQ_BIT 0
`define CTRL_GO_ACTIVE_BIT 1
`define STAT_EARLY_BIT 0
`define STAT_TIMEOUT_BIT 1
`define STAT_FAIL_LSB 4
`define STAT_STATE_LSB 8

// Reset and limit values
`define FAIL_INIT 3'h5
`define FAIL_MAX 3'h7
`define FAIL_IN_RANGE_MAX 3'h4
`define FAIL_MIN 3'h0
`define WIN1_DEFAULT 7'h0a
`define WIN2_DEFAULT 5'h04

`endif

// [rtl/watchdog_pkg.sv]
package watchdog_pkg;

    typedef enum logic [1:0] {st_reset, st_diag, st_active} dev_state_t;

    typedef enum logic {ph_closed, ph_open} win_phase_t;

endpackage

// [rtl/timing_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface timing_if;
    logic step_tick;
    logic trigger;

    modport timer (output step_tick);
    modport detect (output trigger);
    modport core (input step_tick, input trigger);
endinterface

`default_nettype wire

// [rtl/step_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module step_timer #(
    parameter int unsigned STEP_CYC = 137500
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_restart,
    // Tick out
    timing_if.timer tif
);
    localparam int W = $clog2(STEP_CYC + 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic last;

    // One 0.55 ms step per wrap, realigned on each new sequence
    assign last = (cnt_q == W'(STEP_CYC - 1));
    assign tif.step_tick = last;

    always_comb begin
        if (i_restart || last) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

`default_nettype wire

// [rtl/trigger_detect.sv]
`timescale 1ns/1ps
`default_nettype none

module trigger_detect #(
    parameter int unsigned PULSE_CYC = 8000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Synchronised pin level
    input wire logic i_level,
    // Trigger out
    timing_if.detect tif
);
    localparam int W = $clog2(PULSE_CYC + 2);

    logic prev_q;
    logic prev_d;
    logic [W-1:0] high_q;
    logic [W-1:0] high_d;
    logic trig_q;
    logic trig_d;

    assign tif.trigger = trig_q;

    // Rise starts the count, fall after more than the pulse time is a trigger
    always_comb begin
        prev_d = i_level;
        high_d = high_q;
        trig_d = 1'b0;
        if (i_level && !prev_q) begin
            high_d = W'(1);
        end else if (i_level && high_q <= W'(PULSE_CYC)) begin
            high_d = high_q + W'(1);
        end
        if (!i_level && prev_q) begin
            trig_d = (high_q > W'(PULSE_CYC));
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q <= 1'b0;
            high_q <= '0;
            trig_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            high_q <= high_d;
            trig_q <= trig_d;
        end
    end
endmodule

`default_nettype wire

// [dv/mcu_model.sv]
`timescale 1ns/1ps
`default_nettype none

module mcu_model (
    // Clock
    input wire logic i_clk,
    // Trigger pin
    output logic o_trig
);
    initial begin
        o_trig = 1'b0;
    end

    // Trigger pin only carries trigger pulses, no error-monitor pattern
    task automatic pulse(input int unsigned high_cyc);
        @(posedge i_clk);
        o_trig <= 1'b1;
        repeat (high_cyc) @(posedge i_clk);
        o_trig <= 1'b0;
    endtask
endmodule

`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.svh"

module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic other_err;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trig;
    logic drive;
    logic mcu_rst_n;
    logic esm_en;
    logic [31:0] rd;
    logic err_flag;
    int miscompares = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    mcu_watchdog #(.STEP_CYC(20), .PULSE_CYC(8), .RESET_HOLD(4)) mcu_watchdog_i (
        .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_mcu_error_trigger_in(trig),
        .i_other_error(other_err), .o_drive_enable_out(drive),
        .o_mcu_reset_out_n(mcu_rst_n), .o_error_signal_monitor_en(esm_en)
    );

    mcu_model mcu_model_i (.i_clk(clk), .o_trig(trig));

    task automatic close_out;
        $display("checked %0d values, %0d wrong", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        cmp({31'h0, pready}, 32'h1);
        rd = prdata;
        err_flag = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic stat(input logic [2:0] fail, input watchdog_pkg::dev_state_t st);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        cmp({29'h0, rd[6:4]}, {29'h0, fail});
        cmp({30'h0, rd[9:8]}, {30'h0, st});
    endtask

    task automatic wait_rst_high;
        int n;
        n = 0;
        while (mcu_rst_n !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
        end
        cmp({31'h0, mcu_rst_n}, 32'h1);
        @(posedge clk);
    endtask

    task automatic t_boot;
        wait_rst_high();
        cmp({31'h0, esm_en}, 32'h0);
        cmp({31'h0, drive}, 32'h0);
        stat(3'h5, watchdog_pkg::st_diag);
    endtask

    task automatic t_triggers;
        apb(1'b1, `ADDR_CTRL, 32'h1);
        mcu_model_i.pulse(12);
        wait_cyc(6);
        stat(3'h6, watchdog_pkg::st_diag);
        cmp({31'h0, rd[`STAT_EARLY_BIT]}, 32'h1);
        for (int i = 0; i < 2; i++) begin
            wait_cyc(220);
            mcu_model_i.pulse(9 + 3 * i);
            wait_cyc(6);
            stat(3'(5 - i), watchdog_pkg::st_diag);
        end
        cmp({31'h0, drive}, 32'h1);
        other_err <= 1'b1;
        wait_cyc(3);
        cmp({31'h0, drive}, 32'h0);
        other_err <= 1'b0;
    endtask

    task automatic t_timeout;
        mcu_model_i.pulse(8);
        wait_cyc(221);
        stat(3'h4, watchdog_pkg::st_diag);
        wait_cyc(90);
        stat(3'h5, watchdog_pkg::st_diag);
        cmp({31'h0, rd[`STAT_TIMEOUT_BIT]}, 32'h1);
        cmp({31'h0, drive}, 32'h0);
    endtask

    task automatic t_qa_reset;
        apb(1'b1, `ADDR_SAFETY_CFG, 32'h20);
        wait_cyc(2);
        cmp({31'h0, esm_en}, 32'h1);
        mcu_model_i.pulse(12);
        wait_cyc(6);
        stat(3'h5, watchdog_pkg::st_diag);
        apb(1'b1, `ADDR_QA, 32'h0);
        stat(3'h6, watchdog_pkg::st_diag);
        apb(1'b0, `ADDR_QA, 32'h0);
        wait_cyc(215);
        apb(1'b1, `ADDR_QA, {24'h0, ~rd[3:0], rd[3:0]});
        stat(3'h5, watchdog_pkg::st_diag);
        apb(1'b1, `ADDR_WIN1, 32'h0a);
        apb(1'b1, `ADDR_WIN1, 32'h0a);
        apb(1'b1, `ADDR_WIN1, 32'h0a);
        stat(3'h7, watchdog_pkg::st_diag);
        apb(1'b1, `ADDR_SAFETY_CFG, 32'h28);
        wait_cyc(1);
        cmp({31'h0, mcu_rst_n}, 32'h0);
        wait_rst_high();
        stat(3'h5, watchdog_pkg::st_diag);
        cmp({31'h0, esm_en}, 32'h0);
    endtask

    task automatic t_reset_on_bad;
        apb(1'b1, `ADDR_SAFETY_CFG, 32'h08);
        apb(1'b1, `ADDR_WIN1, 32'h0a);
        stat(3'h6, watchdog_pkg::st_diag);
        apb(1'b1, `ADDR_WIN1, 32'h0a);
        stat(3'h7, watchdog_pkg::st_diag);
        cmp({31'h0, mcu_rst_n}, 32'h1);
        apb(1'b1, `ADDR_WIN1, 32'h0a);
        wait_cyc(2);
        cmp({31'h0, mcu_rst_n}, 32'h0);
        wait_rst_high();
        stat(3'h5, watchdog_pkg::st_diag);
    endtask

    task automatic t_active;
        apb(1'b1, `ADDR_WIN1, 32'h0a);
        apb(1'b1, `ADDR_CTRL, 32'h2);
        stat(3'h5, watchdog_pkg::st_active);
        apb(1'b0, 8'h20, 32'h0);
        cmp({31'h0, err_flag}, 32'h1);
        cmp(rd, 32'h0);
    endtask

    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0000_0000;
        other_err <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_boot();
        t_triggers();
        t_timeout();
        t_qa_reset();
        t_reset_on_bad();
        t_active();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        close_out();
    end
endmodule

`default_nettype wire
